/* verilog/overlap_timer_top.sv */
// overlap trailing timer and status block with APB register slave
// assumes parent phase states are synchronous to sys_clk
//
// Function
// - trailing green extends green or walk
// - trailing yellow timed in tenths
// - trailing red clearance timed in tenths
// - trailing settings serve vehicle type overlaps
// - ped walk timed, then ped clearance
// - zero walk uses parent walk time
// - ped clearance timed in seconds
// - zero clearance uses parent clearance time
// - listed ped phase suppresses, 3 s after
// - flashing arrow held red likewise, 3 s
// - group count is (overlaps+7)/8
// - one status row per group
// - red mask bit set while red
// - bit 7 is group times eight
// - yellow mask, shows ped clearance
// - green mask bit set while green
`timescale 1ns/1ps
module overlap_timer_top #(
	parameter int TICK_CYCLES = overlap_pkg::TICK_CYCLES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// parent phase sequencer
	input overlap_pkg::parent_in_type
		[overlap_pkg::OVERLAP_COUNT-1:0] parentIn,
	input wire logic [overlap_pkg::PHASE_COUNT-1:0] pedPhaseActive,
	// signal head outputs
	output logic [overlap_pkg::OVERLAP_COUNT-1:0] lampRed,
	output logic [overlap_pkg::OVERLAP_COUNT-1:0] lampYellow,
	output logic [overlap_pkg::OVERLAP_COUNT-1:0] lampGreen
);
	localparam int N = overlap_pkg::OVERLAP_COUNT;
	localparam int TW = $clog2(TICK_CYCLES);
	localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

	// tenth-second divider
	logic [TW-1:0] divQ; // cycle count within a tick
	logic tickQ; // one-cycle tick pulse

	// apb handshake state
	logic readyQ; // access phase answered
	logic [31:0] rdataQ; // captured read data
	logic errQ; // captured error
	logic setup; // setup cycle seen
	logic access; // transfer completes

	// register storage
	overlap_pkg::ovl_cfg_type cfgQ [N]; // timing settings
	logic [31:0] conflictQ [N]; // conflicting ped phases

	// decode results
	logic [31:0] rdData; // read data of the addressed word
	logic hit; // address maps to a register
	logic cfgHit; // address maps to a writable setting
	logic [3:0] ovlIdx; // addressed overlap
	logic [4:0] field; // addressed setting
	logic [11:0] statOfs; // offset into status rows
	logic [11:0] cfgOfs; // offset into setting rows
	logic [7:0] grpIdx; // addressed group, zero based

	// conflict activity per overlap
	logic [N-1:0] conflictHit;

	// divider: one tick per tenth of a second
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			divQ <= '0;
			tickQ <= 1'b0;
		end else if (divQ == TICK_LAST) begin
			divQ <= '0;
			tickQ <= 1'b1;
		end else begin
			divQ <= divQ + TW'(1);
			tickQ <= 1'b0;
		end
	end

	// bus phases
	assign setup = psel && !penable;
	assign access = psel && penable && readyQ;

	// offsets into the two row areas
	assign statOfs = paddr - overlap_pkg::STAT_BASE;
	assign cfgOfs = paddr - overlap_pkg::CFG_BASE;
	assign grpIdx = 8'(statOfs >> overlap_pkg::GRP_SHIFT);
	assign ovlIdx = 4'(cfgOfs >> overlap_pkg::OVL_SHIFT);
	assign field = cfgOfs[4:0];

	// address decode and read mux
	always_comb begin
		rdData = 32'h0000_0000;
		hit = 1'b0;
		cfgHit = 1'b0;
		if (paddr == overlap_pkg::GROUP_COUNT_ADDR) begin
			// fixed group count
			hit = 1'b1;
			rdData[7:0] = overlap_pkg::MAX_GROUPS;
		end else if (paddr >= overlap_pkg::STAT_BASE
			&& grpIdx < overlap_pkg::MAX_GROUPS) begin
			// status rows, group number minus one selects
			hit = 1'b1;
			case (statOfs[3:0])
				overlap_pkg::OFS_RED: begin
					rdData[7:0] = lampRed[grpIdx[0]*8 +: 8];
				end
				overlap_pkg::OFS_YELLOW: begin
					rdData[7:0] = lampYellow[grpIdx[0]*8 +: 8];
				end
				overlap_pkg::OFS_GREEN: begin
					rdData[7:0] = lampGreen[grpIdx[0]*8 +: 8];
				end
				default: begin
					hit = 1'b0;
				end
			endcase
		end
		if (paddr >= overlap_pkg::CFG_BASE
			&& cfgOfs < overlap_pkg::CFG_SPAN) begin
			// per-overlap settings
			hit = 1'b1;
			cfgHit = 1'b1;
			case (field)
				overlap_pkg::OFS_TRAIL_GREEN: begin
					rdData[7:0] = cfgQ[ovlIdx].trailGreen;
				end
				overlap_pkg::OFS_TRAIL_YELLOW: begin
					rdData[7:0] = cfgQ[ovlIdx].trailYellow;
				end
				overlap_pkg::OFS_TRAIL_RED: begin
					rdData[7:0] = cfgQ[ovlIdx].trailRed;
				end
				overlap_pkg::OFS_WALK: begin
					rdData[7:0] = cfgQ[ovlIdx].walk;
				end
				overlap_pkg::OFS_PED_CLEAR: begin
					rdData[7:0] = cfgQ[ovlIdx].pedClear;
				end
				overlap_pkg::OFS_KIND: begin
					rdData[1:0] = cfgQ[ovlIdx].kind;
				end
				overlap_pkg::OFS_CONFLICT: begin
					rdData = conflictQ[ovlIdx];
				end
				default: begin
					hit = 1'b0;
					cfgHit = 1'b0;
				end
			endcase
		end
	end

	// apb answer: ready in the first access cycle
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			readyQ <= 1'b0;
			rdataQ <= 32'h0000_0000;
			errQ <= 1'b0;
		end else begin
			readyQ <= setup;
			if (setup) begin
				// status is sampled in the setup cycle
				rdataQ <= pwrite ? 32'h0000_0000 : rdData;
				errQ <= !hit || (pwrite && !cfgHit);
			end
		end
	end

	// bus outputs from flops
	assign prdata = rdataQ;
	assign pready = readyQ;
	assign pslverr = errQ;

	// setting registers, written in the completing cycle
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			for (int i = 0; i < N; i++) begin
				cfgQ[i].kind <= overlap_pkg::KIND_NORMAL;
				cfgQ[i].trailGreen <= overlap_pkg::RST_ZERO;
				cfgQ[i].trailYellow <= overlap_pkg::RST_TRAIL_YELLOW;
				cfgQ[i].trailRed <= overlap_pkg::RST_ZERO;
				cfgQ[i].walk <= overlap_pkg::RST_ZERO;
				cfgQ[i].pedClear <= overlap_pkg::RST_ZERO;
				conflictQ[i] <= 32'h0000_0000;
			end
		end else if (access && pwrite && cfgHit) begin
			case (field)
				overlap_pkg::OFS_TRAIL_GREEN: begin
					cfgQ[ovlIdx].trailGreen <= pwdata[7:0];
				end
				overlap_pkg::OFS_TRAIL_YELLOW: begin
					cfgQ[ovlIdx].trailYellow <= pwdata[7:0];
				end
				overlap_pkg::OFS_TRAIL_RED: begin
					cfgQ[ovlIdx].trailRed <= pwdata[7:0];
				end
				overlap_pkg::OFS_WALK: begin
					cfgQ[ovlIdx].walk <= pwdata[7:0];
				end
				overlap_pkg::OFS_PED_CLEAR: begin
					cfgQ[ovlIdx].pedClear <= pwdata[7:0];
				end
				overlap_pkg::OFS_KIND: begin
					cfgQ[ovlIdx].kind <= overlap_pkg::kind_type'(pwdata[1:0]);
				end
				overlap_pkg::OFS_CONFLICT: begin
					conflictQ[ovlIdx] <= pwdata;
				end
				default: begin
					cfgQ[ovlIdx].kind <= cfgQ[ovlIdx].kind;
				end
			endcase
		end
	end

	// conflict lookup: one phase per byte, zero is an empty slot
	always_comb begin
		logic [7:0] ph;
		ph = 8'h00;
		conflictHit = '0;
		for (int o = 0; o < N; o++) begin
			for (int s = 0; s < overlap_pkg::CONFLICT_SLOTS; s++) begin
				ph = conflictQ[o][s*8 +: 8];
				// out of range numbers are ignored
				if (ph != 8'h00
					&& ph <= 8'(overlap_pkg::PHASE_COUNT)
					&& pedPhaseActive[4'(ph - 8'h01)]) begin
					conflictHit[o] = 1'b1;
				end
			end
		end
	end

	// one timer per overlap
	for (genvar gi = 0; gi < N; gi++) begin : g_ovl
		overlap_channel u_chan (
			.sys_clk(sys_clk),
			.sys_rst(sys_rst),
			.tick(tickQ),
			.cfg(cfgQ[gi]),
			.parentIn(parentIn[gi]),
			.conflict(conflictHit[gi]),
			.lampRed(lampRed[gi]),
			.lampYellow(lampYellow[gi]),
			.lampGreen(lampGreen[gi])
		);
	end

	// bus and status checks
	apb_ready_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		setup ##1 psel && penable |-> pready)
		else $error("access phase not answered");
	group_count_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		setup && !pwrite && paddr == 12'h000
		|=> prdata == 32'h0000_0002 && !pslverr)
		else $error("group count wrong");
	red_map_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		setup && !pwrite && paddr == 12'h110
		|=> prdata[7] == $past(lampRed[15])
		&& prdata[0] == $past(lampRed[8]) && prdata[31:8] == 24'h0)
		else $error("red mask bit order wrong");
	yellow_map_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		setup && !pwrite && paddr == 12'h104
		|=> prdata[7:0] == $past(lampYellow[7:0]))
		else $error("yellow mask wrong");
	green_map_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		setup && !pwrite && paddr == 12'h108
		|=> prdata[7:0] == $past(lampGreen[7:0]))
		else $error("green mask wrong");
	ro_write_a: assert property (@(posedge sys_clk)
		disable iff (sys_rst)
		setup && pwrite && paddr == 12'h100 |=> pslverr)
		else $error("status write not refused");
	bus_read_c: cover property (@(posedge sys_clk) access && !pwrite);
endmodule : overlap_timer_top

/* verilog/overlap_pkg.sv */
// overlap timer package: sizes, map, reset values, types
// assumes a 100 MHz sys_clk and a 0.1 s interval tick
package overlap_pkg;
	// sizes
	localparam int OVERLAP_COUNT = 16;
	localparam int PHASE_COUNT = 16;
	localparam int GROUP_SIZE = 8;
	localparam int GROUP_NUM = (OVERLAP_COUNT + GROUP_SIZE - 1) / GROUP_SIZE;
	localparam logic [7:0] MAX_GROUPS = 8'(GROUP_NUM);
	localparam int CONFLICT_SLOTS = 4;
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_PERIOD_NS = 100_000_000;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int PED_CLEAR_S = 3;
	localparam logic [11:0] PED_CLEAR_TICKS = 12'(PED_CLEAR_S * 10);
	localparam logic [11:0] HOLD_TICKS = PED_CLEAR_TICKS + 12'h001;
	localparam logic [11:0] SEC_TO_TICKS = 12'h00a;
	// register map (byte addresses)
	localparam logic [11:0] GROUP_COUNT_ADDR = 12'h000;
	localparam logic [11:0] STAT_BASE = 12'h100;
	localparam int GRP_SHIFT = 4;
	localparam logic [3:0] OFS_RED = 4'h0;
	localparam logic [3:0] OFS_YELLOW = 4'h4;
	localparam logic [3:0] OFS_GREEN = 4'h8;
	localparam logic [11:0] CFG_BASE = 12'h400;
	localparam logic [11:0] CFG_SPAN = 12'h200;
	localparam int OVL_SHIFT = 5;
	localparam logic [4:0] OFS_TRAIL_GREEN = 5'h00;
	localparam logic [4:0] OFS_TRAIL_YELLOW = 5'h04;
	localparam logic [4:0] OFS_TRAIL_RED = 5'h08;
	localparam logic [4:0] OFS_WALK = 5'h0c;
	localparam logic [4:0] OFS_PED_CLEAR = 5'h10;
	localparam logic [4:0] OFS_KIND = 5'h14;
	localparam logic [4:0] OFS_CONFLICT = 5'h18;
	// reset values
	localparam logic [7:0] RST_TRAIL_YELLOW = 8'h1e;
	localparam logic [7:0] RST_ZERO = 8'h00;
	// overlap kinds
	typedef enum logic [1:0] {
		KIND_NORMAL, KIND_PED, KIND_FYA3, KIND_FYA4
	} kind_type;
	// per-overlap settings
	typedef struct packed {
		kind_type kind;
		logic [7:0] trailGreen;
		logic [7:0] trailYellow;
		logic [7:0] trailRed;
		logic [7:0] walk;
		logic [7:0] pedClear;
	} ovl_cfg_type;
	// parent phase state seen by one overlap
	typedef struct packed {
		logic green;
		logic yellow;
		logic walk;
		logic [7:0] walkTime;
		logic [7:0] clearTime;
	} parent_in_type;
endpackage : overlap_pkg

/* verilog/overlap_channel.sv */
// one overlap: trailing, clearance, walk and conflict hold timing
// assumes tick is a one-cycle pulse every tenth of a second
`timescale 1ns/1ps
module overlap_channel (
	// clock, reset, interval tick
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic tick,
	// settings and parent state
	input overlap_pkg::ovl_cfg_type cfg,
	input overlap_pkg::parent_in_type parentIn,
	input wire logic conflict,
	// lamp state
	output logic lampRed,
	output logic lampYellow,
	output logic lampGreen
);
	typedef enum logic [2:0] {
		IDLE_RED, GREEN_ON, TRAIL_ON, TRAIL_YEL,
		TRAIL_RCLR, PARENT_YEL, WALK_ON, PED_CLR
	} state_type;
	state_type stateQ, stateD; // interval state
	logic [11:0] cntQ, cntD; // interval countdown in ticks
	logic [11:0] holdQ; // conflict clearance countdown
	logic isPed, blocked, done;
	logic [11:0] trailT, walkT, clrT, yelT, redT;

	// timer loads, seconds scaled to ticks
	assign isPed = cfg.kind == overlap_pkg::KIND_PED;
	assign trailT = 12'(cfg.trailGreen) * overlap_pkg::SEC_TO_TICKS;
	assign yelT = 12'(cfg.trailYellow);
	assign redT = 12'(cfg.trailRed);
	assign walkT = (cfg.walk != 8'h00 ? 12'(cfg.walk)
		: 12'(parentIn.walkTime)) * overlap_pkg::SEC_TO_TICKS;
	assign clrT = (cfg.pedClear != 8'h00 ? 12'(cfg.pedClear)
		: 12'(parentIn.clearTime)) * overlap_pkg::SEC_TO_TICKS;
	assign blocked = !isPed && (conflict || holdQ != 12'h000);
	assign done = tick && cntQ == 12'h000;

	// conflict hold: reloads while a listed ped phase runs
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			holdQ <= 12'h000;
		end else if (conflict && !isPed) begin
			holdQ <= overlap_pkg::HOLD_TICKS;
		end else if (tick && holdQ != 12'h000) begin
			holdQ <= holdQ - 12'h001;
		end
	end

	// next state and counter
	always_comb begin
		stateD = stateQ;
		cntD = (tick && cntQ != 12'h000) ? cntQ - 12'h001 : cntQ;
		case (stateQ)
			IDLE_RED: begin
				if (isPed) begin
					if (parentIn.walk) begin
						stateD = WALK_ON;
						cntD = walkT;
					end
				end else if (parentIn.green && !blocked) begin
					stateD = GREEN_ON;
				end
			end
			GREEN_ON: begin
				if (blocked) begin
					stateD = TRAIL_YEL;
					cntD = yelT;
				end else if (!parentIn.green) begin
					if (cfg.trailGreen != 8'h00) begin
						stateD = TRAIL_ON;
						cntD = trailT;
					end else begin
						stateD = PARENT_YEL;
					end
				end
			end
			TRAIL_ON: begin
				if (!isPed && parentIn.green && !blocked) begin
					stateD = GREEN_ON;
				end else if (done && isPed) begin
					stateD = PED_CLR;
					cntD = clrT;
				end else if (done) begin
					stateD = TRAIL_YEL;
					cntD = yelT;
				end
			end
			TRAIL_YEL: begin
				if (done && redT == 12'h000) begin
					stateD = IDLE_RED;
				end else if (done) begin
					stateD = TRAIL_RCLR;
					cntD = redT;
				end
			end
			TRAIL_RCLR: begin
				if (done) begin
					stateD = IDLE_RED;
				end
			end
			PARENT_YEL: begin
				if (parentIn.green && !blocked) begin
					stateD = GREEN_ON;
				end else if (!parentIn.yellow) begin
					stateD = IDLE_RED;
				end
			end
			WALK_ON: begin
				if (done && cfg.trailGreen != 8'h00) begin
					stateD = TRAIL_ON;
					cntD = trailT;
				end else if (done) begin
					stateD = PED_CLR;
					cntD = clrT;
				end
			end
			PED_CLR: begin
				if (done) begin
					stateD = IDLE_RED;
				end
			end
			default: begin
				stateD = IDLE_RED;
			end
		endcase
	end

	// state registers
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			stateQ <= IDLE_RED;
			cntQ <= 12'h000;
		end else begin
			stateQ <= stateD;
			cntQ <= cntD;
		end
	end

	// lamps follow the state; ped clearance shows yellow
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			lampRed <= 1'b1;
			lampYellow <= 1'b0;
			lampGreen <= 1'b0;
		end else begin
			lampGreen <= stateD inside {GREEN_ON, TRAIL_ON, WALK_ON};
			lampYellow <= stateD inside {TRAIL_YEL, PARENT_YEL, PED_CLR};
			lampRed <= stateD inside {IDLE_RED, TRAIL_RCLR};
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	trail_start_a: assert property (
		stateQ == GREEN_ON && !parentIn.green && !blocked
		&& cfg.trailGreen != 8'h00 |=> stateQ == TRAIL_ON
		&& cntQ == 12'($past(cfg.trailGreen)) * 12'h00a && lampGreen)
		else $error("trailing green not started");
	trail_yellow_a: assert property (
		stateQ == TRAIL_ON && done && !isPed && !parentIn.green
		|=> stateQ == TRAIL_YEL && cntQ == 12'($past(cfg.trailYellow)))
		else $error("trailing yellow not loaded");
	trail_red_a: assert property (
		stateQ == TRAIL_YEL && done && cfg.trailRed != 8'h00
		|=> stateQ == TRAIL_RCLR && lampRed)
		else $error("trailing red clearance missing");
	walk_load_a: assert property (
		stateQ == IDLE_RED && isPed && parentIn.walk && cfg.walk == 8'h00
		|=> cntQ == 12'($past(parentIn.walkTime)) * 12'h00a)
		else $error("parent walk time not used");
	clear_load_a: assert property (
		stateQ == WALK_ON && done && cfg.trailGreen == 8'h00
		&& cfg.pedClear == 8'h00
		|=> stateQ == PED_CLR
		&& cntQ == 12'($past(parentIn.clearTime)) * 12'h00a)
		else $error("parent clearance not used");
	conflict_hold_a: assert property (
		$fell(conflict) && !isPed |-> holdQ == 12'd31 && blocked)
		else $error("conflict clearance not held");
	no_trail_a: assert property (
		stateQ == GREEN_ON && !parentIn.green && !blocked
		&& cfg.trailGreen == 8'h00 |=> stateQ == PARENT_YEL)
		else $error("green did not end with parent");
	lamp_onehot_a: assert property (
		##1 $onehot({lampRed, lampYellow, lampGreen}))
		else $error("lamp outputs not one-hot");
	trail_seen_c: cover property (stateQ == TRAIL_ON ##1 stateQ == TRAIL_YEL);
	walk_seen_c: cover property (stateQ == WALK_ON ##1 stateQ == PED_CLR);
	held_c: cover property (stateQ == IDLE_RED && blocked && parentIn.green);
endmodule : overlap_channel

/* test/parent_phase_model.sv */
// parent phase sequencer stand-in: per-overlap parent state, ped phases
// assumes the bench writes one overlap entry per cmdWr pulse
`timescale 1ns/1ps
module parent_phase_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// bench commands
	input wire logic cmdWr,
	input wire logic [3:0] cmdOvl,
	input overlap_pkg::parent_in_type cmdEntry,
	input wire logic [overlap_pkg::PHASE_COUNT-1:0] cmdPed,
	// toward the timer block
	output overlap_pkg::parent_in_type
		[overlap_pkg::OVERLAP_COUNT-1:0] parentIn,
	output logic [overlap_pkg::PHASE_COUNT-1:0] pedPhaseActive
);
	// parent states move only on a clock edge, like a real sequencer
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			parentIn <= '0;
		end else if (cmdWr) begin
			parentIn[cmdOvl] <= cmdEntry;
		end
	end
	// ped phase activity registered the same way
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pedPhaseActive <= '0;
		end else begin
			pedPhaseActive <= cmdPed;
		end
	end
endmodule : parent_phase_model

/* test/test_overlap_trailing_timer_status.sv */
// self-checking bench for the overlap trailing timer and status block
// assumes the tick is shortened to TC clock cycles
`timescale 1ns/1ps
module test_overlap_trailing_timer_status;
	localparam int TC = 10; // cycles per tick
	localparam int SEC = TC * 10; // cycles per second
	// clock, reset and apb
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	// partner command side
	logic cmdWr = 1'b0;
	logic [3:0] cmdOvl = 4'h0;
	overlap_pkg::parent_in_type cmdEntry = '0;
	logic [15:0] cmdPed = 16'h0000;
	overlap_pkg::parent_in_type [15:0] parentIn;
	logic [15:0] pedPhaseActive;
	// lamps
	logic [15:0] lampRed;
	logic [15:0] lampYellow;
	logic [15:0] lampGreen;
	// scoring and scratch
	int miscompares = 0;
	int totalChecks = 0;
	logic [31:0] rd;
	logic err;
	int n;
	int ownW[2] = '{0, 2};
	int ownC[2] = '{0, 1};
	int parW[2] = '{1, 3};
	int parC[2] = '{2, 3};
	int kinds[3] = '{0, 2, 3};

	// device under test with a short tick
	overlap_timer_top #(.TICK_CYCLES(TC)) dut (.sys_clk(sys_clk),
		.sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .parentIn(parentIn),
		.pedPhaseActive(pedPhaseActive), .lampRed(lampRed),
		.lampYellow(lampYellow), .lampGreen(lampGreen));
	// far side model
	parent_phase_model partner (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.cmdWr(cmdWr), .cmdOvl(cmdOvl), .cmdEntry(cmdEntry), .cmdPed(cmdPed),
		.parentIn(parentIn), .pedPhaseActive(pedPhaseActive));

	// 100 MHz clock
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end

	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// measured count inside a window
	task automatic inRange(input int v, input int lo, input int hi);
		check(32'(v >= lo && v <= hi), 32'h1);
	endtask : inRange
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// wait for the answer; only the watchdog ends a hang
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// read and compare data
	task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask : rdChk
	// access that must be refused
	task automatic errChk(input logic wr, input logic [11:0] a);
		apb(wr, a, 32'h0000_00ff);
		check(32'(err), 32'h1);
	endtask : errChk
	// settings address of one overlap field
	function automatic logic [11:0] cfgA(input int o, input logic [4:0] f);
		return overlap_pkg::CFG_BASE + 12'(o << overlap_pkg::OVL_SHIFT) + 12'(f);
	endfunction : cfgA
	// status address of one group row field
	function automatic logic [11:0] statA(input int g, input logic [3:0] f);
		return overlap_pkg::STAT_BASE + 12'((g - 1) << overlap_pkg::GRP_SHIFT)
			+ 12'(f);
	endfunction : statA
	// write one setting
	task automatic cfgW(input int o, input logic [4:0] f, input int v);
		apb(1'b1, cfgA(o, f), 32'(v));
	endtask : cfgW
	// parent state of one overlap: {green, yellow, walk}
	task automatic setParent(input int o, input logic [2:0] gyw,
		input int wt, input int ct);
		@(posedge sys_clk);
		cmdWr <= 1'b1;
		cmdOvl <= 4'(o);
		cmdEntry <= {gyw, 8'(wt), 8'(ct)};
		@(posedge sys_clk);
		cmdWr <= 1'b0;
	endtask : setParent
	// ped phase activity
	task automatic setPed(input logic [15:0] v);
		@(posedge sys_clk);
		cmdPed <= v;
	endtask : setPed
	// lamp by colour: 0 red, 1 yellow, 2 green
	function automatic logic lampOf(input int o, input int c);
		return c == 0 ? lampRed[o] : (c == 1 ? lampYellow[o] : lampGreen[o]);
	endfunction : lampOf
	// cycles until a lamp lights, bounded
	task automatic waitLamp(input int o, input int c, input int maxN);
		n = 0;
		while (lampOf(o, c) !== 1'b1 && n < maxN) begin
			@(posedge sys_clk);
			n++;
		end
		check(32'(n < maxN), 32'h1);
	endtask : waitLamp
	// counts, verdict, end of run
	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", totalChecks, miscompares);
		if (miscompares == 0 && totalChecks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : giveVerdict

	// watchdog: the whole sequence needs about 2000 cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		$display("watchdog expired");
		giveVerdict();
	end

	// main sequence
	initial begin
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		// registers, reset values and refusals
		rdChk(12'h000, 32'((overlap_pkg::OVERLAP_COUNT + 7) / 8));
		rdChk(cfgA(0, overlap_pkg::OFS_TRAIL_YELLOW),
			{24'h0, overlap_pkg::RST_TRAIL_YELLOW});
		rdChk(cfgA(0, overlap_pkg::OFS_TRAIL_GREEN), 32'h0);
		errChk(1'b1, 12'h000);
		errChk(1'b1, statA(1, overlap_pkg::OFS_RED));
		errChk(1'b0, statA(3, overlap_pkg::OFS_RED));
		errChk(1'b0, 12'h41c);
		errChk(1'b0, 12'h402);
		cfgW(0, overlap_pkg::OFS_TRAIL_GREEN, 32'hffff_ff01);
		rdChk(cfgA(0, overlap_pkg::OFS_TRAIL_GREEN), 32'h1);
		$display("test registers done");
		// status masks: overlap 16 is bit 7 of group 2
		setParent(15, 3'b100, 0, 0);
		waitLamp(15, 2, 20);
		rdChk(statA(2, overlap_pkg::OFS_RED), 32'h7f);
		rdChk(statA(2, overlap_pkg::OFS_YELLOW), 32'h0);
		rdChk(statA(2, overlap_pkg::OFS_GREEN), 32'h80);
		rdChk(statA(1, overlap_pkg::OFS_GREEN), 32'h0);
		setParent(15, 3'b000, 0, 0);
		waitLamp(15, 0, 20);
		$display("test status done");
		// trailing green 1 s, yellow 5 tenths, red 3 tenths
		cfgW(0, overlap_pkg::OFS_TRAIL_YELLOW, 5);
		cfgW(0, overlap_pkg::OFS_TRAIL_RED, 3);
		setParent(0, 3'b100, 0, 0);
		waitLamp(0, 2, 20);
		setParent(0, 3'b000, 0, 0);
		waitLamp(0, 1, 400);
		inRange(n, SEC - 2, SEC + TC + 5);
		waitLamp(0, 0, 400);
		inRange(n, 5 * TC - 2, 6 * TC + 3);
		// red clearance keeps the overlap red though the parent is green
		setParent(0, 3'b100, 0, 0);
		waitLamp(0, 2, 100);
		inRange(n, 3 * TC - 2, 4 * TC + 3);
		// zero trailing green: yellow and red follow the parent
		setParent(1, 3'b100, 0, 0);
		waitLamp(1, 2, 20);
		setParent(1, 3'b010, 0, 0);
		waitLamp(1, 1, 10);
		repeat (20) @(posedge sys_clk);
		setParent(1, 3'b000, 0, 0);
		waitLamp(1, 0, 10);
		$display("test trailing done");
		// ped overlap: own times, or parent times when zero
		cfgW(2, overlap_pkg::OFS_KIND, 32'(overlap_pkg::KIND_PED));
		for (int i = 0; i < 2; i++) begin
			cfgW(2, overlap_pkg::OFS_WALK, ownW[i]);
			cfgW(2, overlap_pkg::OFS_PED_CLEAR, ownC[i]);
			setParent(2, 3'b001, parW[i], parC[i]);
			waitLamp(2, 2, 20);
			setParent(2, 3'b000, parW[i], parC[i]);
			waitLamp(2, 1, 1000);
			inRange(n, (ownW[i] ? ownW[i] : parW[i]) * SEC - 6,
				(ownW[i] ? ownW[i] : parW[i]) * SEC + TC + 4);
			rdChk(statA(1, overlap_pkg::OFS_YELLOW), 32'h04);
			waitLamp(2, 0, 1000);
			inRange(n, (ownC[i] ? ownC[i] : parC[i]) * SEC - 12,
				(ownC[i] ? ownC[i] : parC[i]) * SEC + TC + 4);
		end
		$display("test ped done");
		// conflicting ped phase 5 holds overlap 4 red, all held kinds
		cfgW(3, overlap_pkg::OFS_CONFLICT, 32'h0000_0005);
		for (int k = 0; k < 3; k++) begin
			cfgW(3, overlap_pkg::OFS_KIND, kinds[k]);
			setPed(16'h0010);
			setParent(3, 3'b100, 0, 0);
			repeat (50) @(posedge sys_clk);
			check(32'({lampRed[3], lampGreen[3]}), 32'h2);
			setPed(16'h0000);
			waitLamp(3, 2, 500);
			inRange(n, 3 * SEC, 3 * SEC + TC + 6);
			setParent(3, 3'b000, 0, 0);
			waitLamp(3, 0, 600);
		end
		$display("test conflict done");
		giveVerdict();
	end
endmodule : test_overlap_trailing_timer_status
